// ===== rf_cfg_pkg.sv
// Behaviour
// - Modulation pulse lasts width field plus one
// - Gain field bits 6..4 selects receiver gain
// - N-driver upper nibble sets idle conductance
// - N-driver lower nibble sets modulated conductance
// - Soft power-down forces conductance MSBs high
// - N-driver fields apply only with driver on
// - P-driver idle register: six bits, reset 20h
// - Reserved slots reset 88h and 87h, inert
// - Receiver config resets 48h, gain 33 dB
`default_nettype none
package rf_cfg_pkg;

    // Register offsets
    localparam logic [5:0] OFS_RESERVED_A  = 6'h23;
    localparam logic [5:0] OFS_PULSE_WIDTH = 6'h24;
    localparam logic [5:0] OFS_RESERVED_B  = 6'h25;
    localparam logic [5:0] OFS_RX_GAIN_CFG = 6'h26;
    localparam logic [5:0] OFS_N_DRIVER    = 6'h27;
    localparam logic [5:0] OFS_P_IDLE      = 6'h28;

    // Values after reset
    localparam logic [7:0] RST_RESERVED_A  = 8'h88;
    localparam logic [7:0] RST_PULSE_WIDTH = 8'h26;
    localparam logic [7:0] RST_RESERVED_B  = 8'h87;
    localparam logic [7:0] RST_RX_GAIN_CFG = 8'h48;
    localparam logic [7:0] RST_N_DRIVER    = 8'h88;
    localparam logic [7:0] RST_P_IDLE      = 8'h20;

    // Writable bits of each mixed register
    localparam logic [7:0] MASK_RX_GAIN_CFG = 8'h70;
    localparam logic [7:0] MASK_P_IDLE      = 8'h3F;

    // Field positions
    localparam int GAIN_LSB   = 4;
    localparam int GAIN_MSB   = 6;
    localparam int N_IDLE_LSB = 4;
    localparam int N_IDLE_MSB = 7;
    localparam int N_MOD_LSB  = 0;
    localparam int N_MOD_MSB  = 3;
    localparam int P_IDLE_MSB = 5;

    // Receiver gain figures in dB
    localparam logic [5:0] GAIN_DB_18 = 6'h12;
    localparam logic [5:0] GAIN_DB_23 = 6'h17;
    localparam logic [5:0] GAIN_DB_33 = 6'h21;
    localparam logic [5:0] GAIN_DB_38 = 6'h26;
    localparam logic [5:0] GAIN_DB_43 = 6'h2B;
    localparam logic [5:0] GAIN_DB_48 = 6'h30;

    // Value read from an unmapped offset
    localparam logic [7:0] UNMAPPED_READ = 8'h00;

    // Pulse timer states
    typedef enum logic [1:0] {
        PULSE_IDLE   = 2'b01,
        PULSE_ACTIVE = 2'b10
    } pulse_state_t;

endpackage
`default_nettype wire

// ===== mod_pulse_timer.sv
`timescale 1ns/1ps
`default_nettype none
// Stretches a start strobe into a pulse of width plus one clock periods
module mod_pulse_timer #(
    parameter int WIDTH_BITS = 8
) (
    // Clock and reset
    input  wire logic                  clk,
    input  wire logic                  rst,
    // Request
    input  wire logic                  start,
    input  wire logic [WIDTH_BITS-1:0] width,
    // Pulse
    output logic                       pulse,
    output logic                       busy
);

    rf_cfg_pkg::pulse_state_t state_r;   // Current state
    rf_cfg_pkg::pulse_state_t state_nxt; // Next state
    logic [WIDTH_BITS-1:0]    count_r;   // Cycles still to run after this one
    logic [WIDTH_BITS-1:0]    count_nxt; // Next count
    logic                     last;      // Final cycle of the pulse

    assign last  = (count_r == '0);
    assign pulse = (state_r == rf_cfg_pkg::PULSE_ACTIVE);
    assign busy  = pulse;

    // Next state; a start while busy is dropped so a pulse is never cut
    always_comb begin
        state_nxt = state_r;
        count_nxt = count_r;
        unique case (state_r)
            rf_cfg_pkg::PULSE_IDLE: begin
                if (start) begin
                    // Width latched here, later writes do not disturb it
                    state_nxt = rf_cfg_pkg::PULSE_ACTIVE;
                    count_nxt = width;
                end
            end
            rf_cfg_pkg::PULSE_ACTIVE: begin
                if (last) begin
                    state_nxt = rf_cfg_pkg::PULSE_IDLE;
                end else begin
                    count_nxt = count_r - 1'b1;
                end
            end
            default: begin
                // Illegal code recovers to idle
                state_nxt = rf_cfg_pkg::PULSE_IDLE;
                count_nxt = '0;
            end
        endcase
    end

    // State registers
    always_ff @(posedge clk) begin
        if (rst) begin
            state_r <= rf_cfg_pkg::PULSE_IDLE;
            count_r <= '0;
        end else begin
            state_r <= state_nxt;
            count_r <= count_nxt;
        end
    end

endmodule
`default_nettype wire

// ===== rf_front_end_config_regs.sv
`timescale 1ns/1ps
`default_nettype none
// Configuration bank for the RF front end: modulation width, receiver
// gain and antenna driver conductances, with the outputs that steer the
// analog drivers, the receiver and the modulator.
module rf_front_end_config_regs #(
    parameter int ADDR_BITS = 6,
    parameter int DATA_BITS = 8
) (
    // Clock and reset
    input  wire logic                 MCLK,
    input  wire logic                 RST,
    // Register access port
    input  wire logic [ADDR_BITS-1:0] REG_ADDR,
    input  wire logic                 REG_WR_EN,
    input  wire logic [DATA_BITS-1:0] REG_WDATA,
    input  wire logic                 REG_RD_EN,
    output logic      [DATA_BITS-1:0] REG_RDATA,
    output logic                      REG_RD_VALID,
    // Operating state of the analog side
    input  wire logic                 SOFT_PD,
    input  wire logic                 ANT_DRV1_ON,
    input  wire logic                 ANT_DRV2_ON,
    // Miller modulator
    input  wire logic                 MOD_START,
    output logic                      MOD_PULSE,
    output logic                      MOD_BUSY,
    // Receiver
    output logic      [2:0]           RX_GAIN_CODE,
    output logic      [5:0]           RX_GAIN_DB,
    // Driver conductances
    output logic      [3:0]           N_IDLE_G,
    output logic      [3:0]           N_MOD_G,
    output logic      [3:0]           N_ACTIVE_G,
    output logic      [5:0]           P_IDLE_G
);

    // ------------------------------------------------------------------
    // Storage: only the writable fields are held in flip-flops. Reserved
    // slots and reserved bits are constants, which keeps them immune to
    // stray writes and saves area.
    // ------------------------------------------------------------------
    logic [7:0] pulse_width_r;      // Modulation pulse width field
    logic [2:0] gain_r;             // Receiver gain field
    logic [3:0] n_idle_r;           // N-driver idle conductance
    logic [3:0] n_mod_r;            // N-driver modulated conductance
    logic [5:0] p_idle_r;           // P-driver idle conductance

    // Address decode
    logic       hit_pulse_width;    // Write to width register
    logic       hit_gain;           // Write to receiver config
    logic       hit_n_driver;       // Write to n-driver register
    logic       hit_p_idle;         // Write to p-driver register

    assign hit_pulse_width = REG_WR_EN
                           && (REG_ADDR == rf_cfg_pkg::OFS_PULSE_WIDTH);
    assign hit_gain        = REG_WR_EN
                           && (REG_ADDR == rf_cfg_pkg::OFS_RX_GAIN_CFG);
    assign hit_n_driver    = REG_WR_EN
                           && (REG_ADDR == rf_cfg_pkg::OFS_N_DRIVER);
    assign hit_p_idle      = REG_WR_EN
                           && (REG_ADDR == rf_cfg_pkg::OFS_P_IDLE);

    // Reset values split into the stored fields
    localparam logic [2:0] GAIN_RST =
        rf_cfg_pkg::RST_RX_GAIN_CFG[rf_cfg_pkg::GAIN_MSB:rf_cfg_pkg::GAIN_LSB];
    localparam logic [3:0] N_IDLE_RST =
        rf_cfg_pkg::RST_N_DRIVER[rf_cfg_pkg::N_IDLE_MSB:rf_cfg_pkg::N_IDLE_LSB];
    localparam logic [3:0] N_MOD_RST =
        rf_cfg_pkg::RST_N_DRIVER[rf_cfg_pkg::N_MOD_MSB:rf_cfg_pkg::N_MOD_LSB];
    localparam logic [5:0] P_IDLE_RST =
        rf_cfg_pkg::RST_P_IDLE[rf_cfg_pkg::P_IDLE_MSB:0];

    // Width register, full eight bits writable
    always_ff @(posedge MCLK) begin
        if (RST) begin
            pulse_width_r <= rf_cfg_pkg::RST_PULSE_WIDTH;
        end else if (hit_pulse_width) begin
            pulse_width_r <= REG_WDATA[7:0];
        end
    end

    // Receiver gain: only bits 6..4 are taken
    always_ff @(posedge MCLK) begin
        if (RST) begin
            gain_r <= GAIN_RST;
        end else if (hit_gain) begin
            gain_r <=
                REG_WDATA[rf_cfg_pkg::GAIN_MSB:rf_cfg_pkg::GAIN_LSB];
        end
    end

    // N-driver register, two nibbles
    always_ff @(posedge MCLK) begin
        if (RST) begin
            n_idle_r <= N_IDLE_RST;
            n_mod_r  <= N_MOD_RST;
        end else if (hit_n_driver) begin
            n_idle_r <=
                REG_WDATA[rf_cfg_pkg::N_IDLE_MSB:rf_cfg_pkg::N_IDLE_LSB];
            n_mod_r  <=
                REG_WDATA[rf_cfg_pkg::N_MOD_MSB:rf_cfg_pkg::N_MOD_LSB];
        end
    end

    // P-driver idle register, upper two bits dropped
    always_ff @(posedge MCLK) begin
        if (RST) begin
            p_idle_r <= P_IDLE_RST;
        end else if (hit_p_idle) begin
            p_idle_r <= REG_WDATA[rf_cfg_pkg::P_IDLE_MSB:0];
        end
    end

    // ------------------------------------------------------------------
    // Read path. The data is registered, so it shows one cycle after the
    // request together with the valid strobe.
    // ------------------------------------------------------------------
    logic [7:0] gain_view;   // Receiver config as read back
    logic [7:0] n_view;      // N-driver register as read back
    logic [7:0] p_view;      // P-driver register as read back
    logic [7:0] rd_mux;      // Selected read value

    // Reserved bits of mixed registers read back their reset value
    assign gain_view = (rf_cfg_pkg::RST_RX_GAIN_CFG
                        & ~rf_cfg_pkg::MASK_RX_GAIN_CFG)
                     | {1'b0, gain_r, 4'h0};
    assign n_view    = {n_idle_r, n_mod_r};
    assign p_view    = (rf_cfg_pkg::RST_P_IDLE & ~rf_cfg_pkg::MASK_P_IDLE)
                     | {2'b00, p_idle_r};

    // Read selection; unmapped offsets answer with zero
    always_comb begin
        unique case (REG_ADDR)
            rf_cfg_pkg::OFS_RESERVED_A:
                rd_mux = rf_cfg_pkg::RST_RESERVED_A;
            rf_cfg_pkg::OFS_PULSE_WIDTH: rd_mux = pulse_width_r;
            rf_cfg_pkg::OFS_RESERVED_B:
                rd_mux = rf_cfg_pkg::RST_RESERVED_B;
            rf_cfg_pkg::OFS_RX_GAIN_CFG: rd_mux = gain_view;
            rf_cfg_pkg::OFS_N_DRIVER:    rd_mux = n_view;
            rf_cfg_pkg::OFS_P_IDLE:      rd_mux = p_view;
            default:                     rd_mux = rf_cfg_pkg::UNMAPPED_READ;
        endcase
    end

    // Read data and strobe registers
    always_ff @(posedge MCLK) begin
        if (RST) begin
            REG_RDATA    <= '0;
            REG_RD_VALID <= 1'b0;
        end else begin
            REG_RD_VALID <= REG_RD_EN;
            if (REG_RD_EN) begin
                REG_RDATA <= rd_mux;
            end
        end
    end

    // ------------------------------------------------------------------
    // Receiver gain decode. Codes 000/010 and 001/011 alias, so only the
    // top and bottom bits matter below 100.
    // ------------------------------------------------------------------
    function automatic logic [5:0] gain_to_db(input logic [2:0] code);
        logic [5:0] db;
        db = rf_cfg_pkg::GAIN_DB_18;
        unique case (code)
            3'h0, 3'h2: db = rf_cfg_pkg::GAIN_DB_18;
            3'h1, 3'h3: db = rf_cfg_pkg::GAIN_DB_23;
            3'h4:       db = rf_cfg_pkg::GAIN_DB_33;
            3'h5:       db = rf_cfg_pkg::GAIN_DB_38;
            3'h6:       db = rf_cfg_pkg::GAIN_DB_43;
            3'h7:       db = rf_cfg_pkg::GAIN_DB_48;
        endcase
        return db;
    endfunction

    logic [5:0] gain_db; // Decoded gain figure

    assign gain_db = gain_to_db(gain_r);

    // ------------------------------------------------------------------
    // Driver conductances. Soft power-down overrides the programmed MSB
    // but leaves the stored value alone, so the setting returns on wake.
    // ------------------------------------------------------------------
    logic       drv_on;     // Either antenna driver switched on
    logic [3:0] n_idle_eff; // Idle n value after power-down forcing
    logic [3:0] n_mod_eff;  // Modulated n value after forcing
    logic [5:0] p_idle_eff; // Idle p value after forcing
    logic [3:0] n_idle_out; // Idle n value after driver gating
    logic [3:0] n_mod_out;  // Modulated n value after gating
    logic       pulse;      // Modulation pulse from the timer

    assign drv_on     = ANT_DRV1_ON | ANT_DRV2_ON;
    assign n_idle_eff = {n_idle_r[3] | SOFT_PD, n_idle_r[2:0]};
    assign n_mod_eff  = {n_mod_r[3] | SOFT_PD, n_mod_r[2:0]};
    assign p_idle_eff = {p_idle_r[5] | SOFT_PD, p_idle_r[4:0]};

    // With both drivers off the n fields carry no meaning; zero is shown
    assign n_idle_out = drv_on ? n_idle_eff : 4'h0;
    assign n_mod_out  = drv_on ? n_mod_eff  : 4'h0;

    // Output registers for the analog side
    always_ff @(posedge MCLK) begin
        if (RST) begin
            RX_GAIN_CODE <= GAIN_RST;
            RX_GAIN_DB   <= rf_cfg_pkg::GAIN_DB_33;
            N_IDLE_G     <= 4'h0;
            N_MOD_G      <= 4'h0;
            N_ACTIVE_G   <= 4'h0;
            P_IDLE_G     <= P_IDLE_RST;
        end else begin
            RX_GAIN_CODE <= gain_r;
            RX_GAIN_DB   <= gain_db;
            N_IDLE_G     <= n_idle_out;
            N_MOD_G      <= n_mod_out;
            // Driver follows the modulated value while the pulse runs
            N_ACTIVE_G   <= pulse ? n_mod_out : n_idle_out;
            P_IDLE_G     <= p_idle_eff;
        end
    end

    // ------------------------------------------------------------------
    // Modulation pulse. The host is trusted to keep the width within
    // half a bit period; nothing here clips it.
    // ------------------------------------------------------------------
    mod_pulse_timer #(
        .WIDTH_BITS (8)
    ) u_pulse (
        .clk   (MCLK),
        .rst   (RST),
        .start (MOD_START),
        .width (pulse_width_r),
        .pulse (pulse),
        .busy  (MOD_BUSY)
    );

    assign MOD_PULSE = pulse;

endmodule
`default_nettype wire

// ===== rf_cfg_properties.sv
`timescale 1ns/1ps
`default_nettype none
// Checks the bank's outputs against shadow copies of its registers
module rf_cfg_checker #(
    parameter int ADDR_BITS = 6,
    parameter int DATA_BITS = 8
) (
    // Clock, reset and register port
    input wire logic                 MCLK,
    input wire logic                 RST,
    input wire logic [ADDR_BITS-1:0] REG_ADDR,
    input wire logic                 REG_WR_EN,
    input wire logic [DATA_BITS-1:0] REG_WDATA,
    input wire logic                 REG_RD_EN,
    input wire logic [DATA_BITS-1:0] REG_RDATA,
    input wire logic                 REG_RD_VALID,
    // Analog state and modulator
    input wire logic                 SOFT_PD,
    input wire logic                 ANT_DRV1_ON,
    input wire logic                 ANT_DRV2_ON,
    input wire logic                 MOD_START,
    input wire logic                 MOD_PULSE,
    input wire logic                 MOD_BUSY,
    // Receiver and driver settings
    input wire logic [2:0]           RX_GAIN_CODE,
    input wire logic [5:0]           RX_GAIN_DB,
    input wire logic [3:0]           N_IDLE_G,
    input wire logic [3:0]           N_MOD_G,
    input wire logic [3:0]           N_ACTIVE_G,
    input wire logic [5:0]           P_IDLE_G
);
    logic [7:0] w_sh_r;                // Shadow of the width register
    logic [7:0] w_lat_r;               // Width taken by the last start
    logic [8:0] cnt_r;                 // High cycles of the pulse so far
    logic [7:0] n_sh_r;                // Shadow of the n-driver register
    logic [5:0] p_sh_r;                // Shadow of the p-driver field
    wire        drv_on = ANT_DRV1_ON | ANT_DRV2_ON;
    wire  [2:0] wd_gain = REG_WDATA[6:4];
    wire        wr_gain = REG_WR_EN && REG_ADDR == 6'h26;

    // Shadows track host writes; the latch mimics a start being taken
    always_ff @(posedge MCLK) begin
        if (RST) begin
            w_sh_r <= 8'h26;
            n_sh_r <= 8'h88;
            p_sh_r <= 6'h20;
            cnt_r  <= 9'h000;
        end else begin
            if (REG_WR_EN && REG_ADDR == 6'h24) w_sh_r <= REG_WDATA;
            if (REG_WR_EN && REG_ADDR == 6'h27) n_sh_r <= REG_WDATA;
            if (REG_WR_EN && REG_ADDR == 6'h28) p_sh_r <= REG_WDATA[5:0];
            if (MOD_START && !MOD_PULSE) w_lat_r <= w_sh_r;
            cnt_r <= MOD_PULSE ? cnt_r + 9'h001 : 9'h000;
        end
    end

    // Gain in dB as the field selects it: 18, 23, then 33 up in fives
    function automatic logic [5:0] db_of(input logic [2:0] c);
        return c[2] ? 6'h21 + 6'h05 * c[1:0] : (c[0] ? 6'h17 : 6'h12);
    endfunction

    default clocking cb @(posedge MCLK); endclocking
    default disable iff (RST);

    a_pulse_start: assert property (
        MOD_START && !MOD_PULSE |=> MOD_PULSE && MOD_BUSY)
        else $error("pulse did not start after an idle start");
    a_pulse_width: assert property (
        $fell(MOD_PULSE) |-> cnt_r == {1'b0, w_lat_r} + 9'h001)
        else $error("pulse length differs from width plus one");
    a_gain_write: assert property (
        wr_gain |-> ##2 RX_GAIN_CODE == $past(wd_gain, 2))
        else $error("gain code did not follow the write");
    a_gain_decode: assert property (RX_GAIN_DB == db_of(RX_GAIN_CODE))
        else $error("gain dB does not match the gain code");
    a_n_fields: assert property (
        !$past(RST) && !$past(SOFT_PD) && $past(drv_on)
        |-> {N_IDLE_G, N_MOD_G} == $past(n_sh_r))
        else $error("n-driver settings differ from the register");
    a_pd_force: assert property (
        !$past(RST) && $past(SOFT_PD) |-> P_IDLE_G[5]
        && (N_IDLE_G[3] && N_MOD_G[3] || !$past(drv_on)))
        else $error("power-down did not force the top bits");
    a_drv_off: assert property (
        !$past(RST) && !$past(drv_on) |-> N_IDLE_G == 4'h0 && N_MOD_G == 4'h0)
        else $error("n-driver settings applied with drivers off");
    a_p_idle: assert property (
        !$past(RST) && !$past(SOFT_PD) |-> P_IDLE_G == $past(p_sh_r))
        else $error("p-driver setting differs from the register");
    a_active_pick: assert property (
        !$past(RST) |-> N_ACTIVE_G == ($past(MOD_PULSE) ? N_MOD_G : N_IDLE_G))
        else $error("active n setting picks the wrong field");

    c_pulse_done: cover property ($fell(MOD_PULSE));
    c_pd_driving: cover property (SOFT_PD && drv_on);
    c_read_back: cover property (REG_RD_VALID);
endmodule

bind rf_front_end_config_regs rf_cfg_checker #(
    .ADDR_BITS(ADDR_BITS), .DATA_BITS(DATA_BITS)
) checker_i (
    .MCLK(MCLK), .RST(RST), .REG_ADDR(REG_ADDR), .REG_WR_EN(REG_WR_EN),
    .REG_WDATA(REG_WDATA), .REG_RD_EN(REG_RD_EN), .REG_RDATA(REG_RDATA),
    .REG_RD_VALID(REG_RD_VALID), .SOFT_PD(SOFT_PD),
    .ANT_DRV1_ON(ANT_DRV1_ON), .ANT_DRV2_ON(ANT_DRV2_ON),
    .MOD_START(MOD_START), .MOD_PULSE(MOD_PULSE), .MOD_BUSY(MOD_BUSY),
    .RX_GAIN_CODE(RX_GAIN_CODE), .RX_GAIN_DB(RX_GAIN_DB),
    .N_IDLE_G(N_IDLE_G), .N_MOD_G(N_MOD_G), .N_ACTIVE_G(N_ACTIVE_G),
    .P_IDLE_G(P_IDLE_G)
);
`default_nettype wire

// ===== tb_top.sv
`timescale 1ns/1ps
`default_nettype none
// Self-checking bench for the RF front-end configuration bank
module tb_top;
    logic       MCLK, RST, REG_WR_EN, REG_RD_EN, REG_RD_VALID, SOFT_PD;
    logic       ANT_DRV1_ON, ANT_DRV2_ON, MOD_START, MOD_PULSE, MOD_BUSY;
    logic [5:0] REG_ADDR, RX_GAIN_DB, P_IDLE_G;
    logic [7:0] REG_WDATA, REG_RDATA;
    logic [2:0] RX_GAIN_CODE;
    logic [3:0] N_IDLE_G, N_MOD_G, N_ACTIVE_G;
    int         errors, checks, cyc;
    logic [31:0] seed = 32'h0000_0060; // Fixed seed keeps runs repeatable
    logic [31:0] r;
    logic [5:0] adr;   // Random register offset
    logic [7:0] n_exp; // Expected n-driver outputs
    logic [7:0] pw;    // Pulse width under test
    // Widest width the host programs; one less than a power of two
    localparam logic [7:0] W_MAX = 8'h3F;

    rf_front_end_config_regs uut (
        .MCLK(MCLK), .RST(RST), .REG_ADDR(REG_ADDR), .REG_WR_EN(REG_WR_EN),
        .REG_WDATA(REG_WDATA), .REG_RD_EN(REG_RD_EN), .REG_RDATA(REG_RDATA),
        .REG_RD_VALID(REG_RD_VALID), .SOFT_PD(SOFT_PD),
        .ANT_DRV1_ON(ANT_DRV1_ON), .ANT_DRV2_ON(ANT_DRV2_ON),
        .MOD_START(MOD_START), .MOD_PULSE(MOD_PULSE), .MOD_BUSY(MOD_BUSY),
        .RX_GAIN_CODE(RX_GAIN_CODE), .RX_GAIN_DB(RX_GAIN_DB),
        .N_IDLE_G(N_IDLE_G), .N_MOD_G(N_MOD_G), .N_ACTIVE_G(N_ACTIVE_G),
        .P_IDLE_G(P_IDLE_G));

    // Xorshift source for data and operating-state draws
    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction
    // Expected gain figure for each gain code
    function automatic logic [5:0] gain_db(input logic [2:0] c);
        case (c)
            3'h0, 3'h2: return 6'h12;
            3'h1, 3'h3: return 6'h17;
            3'h4: return 6'h21;
            3'h5: return 6'h26;
            3'h6: return 6'h2B;
            default: return 6'h30;
        endcase
    endfunction
    // Expected readback after writing d; reserved bits keep reset pattern
    function automatic logic [7:0] rd_exp(input logic [5:0] a,
                                          input logic [7:0] d);
        case (a)
            6'h23: return 8'h88;
            6'h24, 6'h27: return d;
            6'h25: return 8'h87;
            6'h26: return (d & 8'h70) | 8'h08;
            6'h28: return d & 8'h3F;
            default: return 8'h00;
        endcase
    endfunction

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        checks++;
        if (got !== exp) begin
            errors++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // All drives land 1 ns after a rising edge
    task automatic tick(input int n);
        repeat (n) @(posedge MCLK);
        #1;
    endtask
    task automatic wr(input logic [5:0] a, input logic [7:0] d);
        REG_ADDR = a;
        REG_WDATA = d;
        REG_WR_EN = 1'b1;
        tick(1);
        REG_WR_EN = 1'b0;
        // Idle edge, so a following call never re-raises in this step
        tick(1);
    endtask
    // Read data and valid stand in the cycle after the read edge
    task automatic rd(input logic [5:0] a, input logic [7:0] exp);
        REG_ADDR = a;
        REG_RD_EN = 1'b1;
        tick(1);
        REG_RD_EN = 1'b0;
        chk({7'h00, REG_RD_VALID}, 8'h01);
        chk(REG_RDATA, exp);
        // Idle edge, so a following call never re-raises in this step
        tick(1);
    endtask
    // Start a pulse, try a refused restart inside it when wider than one, count its length
    task automatic pulse(input logic [7:0] w);
        int n;
        wr(6'h24, w);
        // Idle and modulated n settings told apart by the width
        wr(6'h27, {~w[3:0], w[3:0]});
        MOD_START = 1'b1;
        tick(1);
        MOD_START = 1'b0;
        n = 0;
        while (MOD_PULSE === 1'b1 && n < 300) begin
            n++;
            tick(1);
            MOD_START = (n == 1 && w > 8'h01);
        end
        chk(8'(n - 1), w);
        // Output lags the pulse by one cycle: modulated, then idle
        chk({4'h0, N_ACTIVE_G}, {4'h0, w[3:0]});
        tick(1);
        chk({4'h0, N_ACTIVE_G}, {4'h0, ~w[3:0]});
    endtask
    task automatic print_verdict();
        $display("errors %0d checks %0d", errors, checks);
        if (errors == 0 && checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    initial begin
        MCLK = 1'b0;
        forever #20 MCLK = ~MCLK;
    end
    // Hang guard: the whole run needs well under 3000 cycles
    always @(posedge MCLK) begin
        cyc++;
        if (cyc == 5000) begin
            errors++;
            print_verdict();
        end
    end

    initial begin
        RST = 1'b1;
        {REG_WR_EN, REG_RD_EN, SOFT_PD, ANT_DRV1_ON, ANT_DRV2_ON} = '0;
        MOD_START = 1'b0;
        REG_ADDR = 6'h00;
        REG_WDATA = 8'h00;
        tick(2);
        RST = 1'b0;
        // Reset contents, then an unmapped slot
        rd(6'h23, 8'h88);
        rd(6'h24, 8'h26);
        rd(6'h25, 8'h87);
        rd(6'h26, 8'h48);
        rd(6'h27, 8'h88);
        rd(6'h28, 8'h20);
        rd(6'h2A, 8'h00);
        chk({2'h0, RX_GAIN_DB}, 8'h21);
        // Random writes over the range and its neighbours, read straight back
        for (int i = 0; i < 24; i++) begin
            r = rnd();
            adr = 6'h22 + {3'h0, r[2:0]};
            wr(adr, r[15:8]);
            rd(adr, rd_exp(adr, r[15:8]));
        end
        // Every gain code, reserved bits set to show they are ignored
        for (int c = 0; c < 8; c++) begin
            wr(6'h26, {1'b1, 3'(c), 4'hF});
            tick(2);
            chk({5'h00, RX_GAIN_CODE}, 8'(c));
            chk({2'h0, RX_GAIN_DB}, {2'h0, gain_db(3'(c))});
        end
        // Conductances under random power-down and driver states
        for (int i = 0; i < 32; i++) begin
            r = rnd();
            if (i == 0) r[10:0] = 11'h700;
            if (i == 1) r[10:0] = 11'h0FF;
            SOFT_PD = r[8];
            ANT_DRV1_ON = r[9];
            ANT_DRV2_ON = r[10];
            wr(6'h27, r[7:0]);
            wr(6'h28, r[23:16]);
            tick(2);
            n_exp = (r[9] | r[10]) ? r[7:0] | {r[8], 3'h0, r[8], 3'h0} : 8'h00;
            chk({N_IDLE_G, N_MOD_G}, n_exp);
            chk({2'h0, P_IDLE_G}, {2'h0, r[8] | r[21], r[20:16]});
        end
        SOFT_PD = 1'b0;
        ANT_DRV1_ON = 1'b1;
        // Shortest, widest allowed and random pulse widths
        for (int k = 0; k < 6; k++) begin
            r = rnd();
            pw = (k == 0) ? 8'h00 : (k == 1) ? 8'h01 : W_MAX;
            if (k > 2) pw = r[7:0] & W_MAX;
            pulse(pw);
        end
        print_verdict();
    end
endmodule
`default_nettype wire
